// file: verilog/bkpt_regs.svh
`ifndef BKPT_REGS_SVH
`define BKPT_REGS_SVH

// Coprocessor register number that holds the breakpoint bank
`define BKPT_CRN 4'h_e

// Register selects within the breakpoint bank
`define SEL_IBKPT 3'h_0
`define SEL_DADDR 3'h_1
`define SEL_DVALUE 3'h_2
`define SEL_DMASK 3'h_3
`define SEL_DCTRL 3'h_4
`define SEL_FSTATUS 3'h_5

// Field positions
`define IBKPT_EN_BIT 0
`define DCTRL_LOAD_BIT 0
`define DCTRL_STORE_BIT 1
`define DCTRL_SDATA_BIT 2
`define FSR_BKPT_BIT 9
`define STATUS_I_BIT 7

// Reset values
`define REG_RESET 32'h_0000_0000
`define DCTRL_RESET 3'h_0

// Abort entry constants
`define ABORT_MODE 5'h_17
`define PABT_OFFSET 32'h_0000_0004
`define DABT_OFFSET 32'h_0000_0008
`define PABT_VECTOR 32'h_0000_000c
`define DABT_VECTOR 32'h_0000_0010

`endif

// file: verilog/bkpt_pkg.sv
`default_nettype none
package bkpt_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic [3:0] crn;
    logic [2:0] sel;
    logic [31:0] wdata;
  } cp_req_type;

  typedef struct packed {
    logic ack;
    logic refuse;
    logic [31:0] rdata;
  } cp_rsp_type;

  typedef struct packed {
    logic take;
    logic data;
    logic [31:0] link;
    logic [31:0] saved_status;
    logic [31:0] new_status;
    logic [31:0] vector;
  } abort_type;

  // Word-granular address compare, bits 1:0 ignored
  function automatic logic word_match(input logic [31:0] a, input logic [31:0] b);
    return a[31:2] == b[31:2];
  endfunction

endpackage
`default_nettype wire

// file: verilog/store_data_match.sv
`timescale 1ns/1ps
`default_nettype none
module store_data_match #(
  parameter int WIDTH = 32
) (
  // Store data and programmed pattern
  input wire logic [WIDTH-1:0] store_data,
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] mask,
  // Result
  output logic match
);

  wire [WIDTH-1:0] diff = (store_data ^ value) & mask;

  // Zero mask bits drop out of the compare
  assign match = (diff == '0);

endmodule // store_data_match
`default_nettype wire

// file: verilog/abort_entry.sv
`timescale 1ns/1ps
`default_nettype none
`include "bkpt_regs.svh"
module abort_entry (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Abort requests
  input wire logic take_pabt,
  input wire logic take_dabt,
  input wire logic [31:0] pabt_pc,
  input wire logic [31:0] dabt_pc,
  input wire logic [31:0] cur_status,
  // Entry result
  output bkpt_pkg::abort_type entry_q
);

  bkpt_pkg::abort_type entry_d;
  wire any_take = take_pabt | take_dabt;

  // Data abort outranks prefetch abort when both land together
  always_comb begin
    entry_d = '0;
    entry_d.take = any_take;
    entry_d.data = take_dabt;
    entry_d.saved_status = cur_status;
    entry_d.new_status = cur_status;
    entry_d.new_status[4:0] = `ABORT_MODE;
    entry_d.new_status[`STATUS_I_BIT] = 1'b1;
    if (take_dabt) begin
      entry_d.link = dabt_pc + `DABT_OFFSET;
      entry_d.vector = `DABT_VECTOR;
    end else begin
      entry_d.link = pabt_pc + `PABT_OFFSET;
      entry_d.vector = `PABT_VECTOR;
    end
    if (!any_take) begin
      entry_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_q <= '0;
    end else begin
      entry_q <= entry_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_dabt_link_vec: assert property (take_dabt |=> entry_q.take && entry_q.data && entry_q.vector == 32'h_0000_0010 && entry_q.link == $past(dabt_pc) + 32'h_0000_0008)
    else $error("data abort entry wrong");
  a_pabt_link_vec: assert property (take_pabt && !take_dabt |=> entry_q.vector == 32'h_0000_000c && entry_q.link == $past(pabt_pc) + 32'h_0000_0004)
    else $error("prefetch abort entry wrong");
  a_abort_mode: assert property (entry_q.take |-> entry_q.new_status[4:0] == 5'b10111 && entry_q.new_status[7] && entry_q.saved_status == $past(cur_status))
    else $error("abort mode or saved status wrong");

endmodule // abort_entry
`default_nettype wire

// file: verilog/core_breakpoint_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "bkpt_regs.svh"
module core_breakpoint_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Coprocessor register access
  input wire bkpt_pkg::cp_req_type cp_req,
  output bkpt_pkg::cp_rsp_type cp_rsp,
  // Fetch stage
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic [31:0] fetch_pc,
  output logic fetch_bkpt_q,
  // Execute stage
  input wire logic exec_valid,
  input wire logic exec_bkpt_tag,
  input wire logic exec_flush,
  input wire logic [31:0] exec_pc,
  input wire logic [31:0] cur_status,
  // Memory stage
  input wire logic mem_valid,
  input wire logic mem_store,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_pc,
  // Fault status and abort entry
  output logic [31:0] fault_status_q,
  output bkpt_pkg::abort_type abort_q
);

  // Reset release synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Breakpoint bank
  logic [31:0] ibkpt_q;
  logic [31:0] daddr_q;
  logic [31:0] dvalue_q;
  logic [31:0] dmask_q;
  logic [2:0] dctrl_q;
  logic [31:0] ibkpt_d;
  logic [31:0] daddr_d;
  logic [31:0] dvalue_d;
  logic [31:0] dmask_d;
  logic [2:0] dctrl_d;
  logic [31:0] fault_status_d;
  bkpt_pkg::cp_rsp_type cp_rsp_d;

  // Access decode
  wire cp_hit = cp_req.valid && (cp_req.crn == `BKPT_CRN);
  wire cp_ok = cp_hit && cp_req.priv;
  wire cp_refuse = cp_hit && !cp_req.priv;
  wire sel_ibkpt = cp_req.sel == `SEL_IBKPT;
  wire sel_daddr = cp_req.sel == `SEL_DADDR;
  wire sel_dvalue = cp_req.sel == `SEL_DVALUE;
  wire sel_dmask = cp_req.sel == `SEL_DMASK;
  wire sel_dctrl = cp_req.sel == `SEL_DCTRL;
  wire sel_fstatus = cp_req.sel == `SEL_FSTATUS;
  wire sel_known = sel_ibkpt | sel_daddr | sel_dvalue | sel_dmask | sel_dctrl | sel_fstatus;
  wire wr_ok = cp_ok && cp_req.write;

  logic [31:0] rd_mux;
  always_comb begin
    if (sel_ibkpt) begin
      rd_mux = ibkpt_q;
    end else if (sel_daddr) begin
      rd_mux = daddr_q;
    end else if (sel_dvalue) begin
      rd_mux = dvalue_q;
    end else if (sel_dmask) begin
      rd_mux = dmask_q;
    end else if (sel_dctrl) begin
      rd_mux = {29'h_0, dctrl_q};
    end else if (sel_fstatus) begin
      rd_mux = fault_status_q;
    end else begin
      rd_mux = `REG_RESET;
    end
  end

  // Unknown selects are refused like non-privileged ones
  always_comb begin
    cp_rsp_d = '0;
    cp_rsp_d.ack = cp_ok && sel_known;
    cp_rsp_d.refuse = cp_refuse || (cp_ok && !sel_known);
    cp_rsp_d.rdata = (cp_ok && !cp_req.write) ? rd_mux : `REG_RESET;
  end

  // Register writes
  assign ibkpt_d = (wr_ok && sel_ibkpt) ? cp_req.wdata : ibkpt_q;
  assign daddr_d = (wr_ok && sel_daddr) ? cp_req.wdata : daddr_q;
  assign dvalue_d = (wr_ok && sel_dvalue) ? cp_req.wdata : dvalue_q;
  assign dmask_d = (wr_ok && sel_dmask) ? cp_req.wdata : dmask_q;
  assign dctrl_d = (wr_ok && sel_dctrl) ? cp_req.wdata[2:0] : dctrl_q;

  // Instruction breakpoint
  wire ibkpt_en = ibkpt_q[`IBKPT_EN_BIT];
  wire fetch_hit = fetch_valid && ibkpt_en &&
    bkpt_pkg::word_match(fetch_addr, ibkpt_q) &&
    bkpt_pkg::word_match(fetch_addr, fetch_pc);

  // Tag only marks the fetch; the core carries it down the pipe
  wire take_pabt = exec_valid && exec_bkpt_tag && !exec_flush;

  // Data breakpoint
  wire en_load = dctrl_q[`DCTRL_LOAD_BIT];
  wire en_store = dctrl_q[`DCTRL_STORE_BIT];
  wire en_sdata = dctrl_q[`DCTRL_SDATA_BIT];
  wire addr_eq = mem_addr == daddr_q;
  logic sdata_eq;

  store_data_match #(
    .WIDTH(32)
  ) u_sdata (
    .store_data(mem_wdata),
    .value(dvalue_q),
    .mask(dmask_q),
    .match(sdata_eq)
  );

  wire load_hit = mem_valid && !mem_store && en_load && addr_eq;
  // Data pattern only narrows a store address hit
  wire store_hit = mem_valid && mem_store && en_store && addr_eq &&
    (!en_sdata || sdata_eq);
  wire take_dabt = load_hit || store_hit;

  // Set wins over a software clear in the same cycle
  always_comb begin
    fault_status_d = fault_status_q;
    if (wr_ok && sel_fstatus) begin
      fault_status_d = cp_req.wdata;
    end
    if (take_dabt) begin
      fault_status_d[`FSR_BKPT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ibkpt_q <= `REG_RESET;
      daddr_q <= `REG_RESET;
      dvalue_q <= `REG_RESET;
      dmask_q <= `REG_RESET;
      dctrl_q <= `DCTRL_RESET;
      fault_status_q <= `REG_RESET;
      cp_rsp <= '0;
      fetch_bkpt_q <= 1'b0;
    end else begin
      ibkpt_q <= ibkpt_d;
      daddr_q <= daddr_d;
      dvalue_q <= dvalue_d;
      dmask_q <= dmask_d;
      dctrl_q <= dctrl_d;
      fault_status_q <= fault_status_d;
      cp_rsp <= cp_rsp_d;
      fetch_bkpt_q <= fetch_hit;
    end
  end

  // Abort entry; no separate debug exception exists
  abort_entry u_entry (
    .clk(clk),
    .rst_n(rst_n_q),
    .take_pabt(take_pabt),
    .take_dabt(take_dabt),
    .pabt_pc(exec_pc),
    .dabt_pc(mem_pc),
    .cur_status(cur_status),
    .entry_q(abort_q)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  a_unpriv_refused: assert property (cp_req.valid && cp_req.crn == 4'he && !cp_req.priv |=> cp_rsp.refuse && !cp_rsp.ack)
    else $error("unprivileged access not refused");
  a_unpriv_nowrite: assert property (cp_req.valid && !cp_req.priv && cp_req.write |=> $stable(ibkpt_q) && $stable(dctrl_q))
    else $error("unprivileged write changed state");
  a_fetch_hit: assert property (fetch_valid && ibkpt_q[0] && fetch_addr[31:2] == ibkpt_q[31:2] && fetch_pc[31:2] == fetch_addr[31:2] |=> fetch_bkpt_q)
    else $error("instruction breakpoint missed");
  a_fetch_off: assert property (!ibkpt_q[0] |=> !fetch_bkpt_q)
    else $error("breakpoint fired while disabled");
  a_flush_drops: assert property (exec_flush && !(mem_valid && dctrl_q != 3'h0) |=> !abort_q.take)
    else $error("flushed prefetch abort taken");
  a_load_addr: assert property (mem_valid && !mem_store && dctrl_q[0] && mem_addr == daddr_q |=> abort_q.take && abort_q.data && fault_status_q[9])
    else $error("load breakpoint missed");
  a_store_needs_addr: assert property (mem_valid && mem_store && !(dctrl_q[1] && mem_addr == daddr_q) && !(exec_valid && exec_bkpt_tag) |=> !abort_q.take)
    else $error("store breakpoint without address match");
  // Data flag, not take, so a same-cycle prefetch abort cannot mask a miss
  a_store_data: assert property (mem_valid && mem_store && dctrl_q == 3'h6 && mem_addr == daddr_q |=> abort_q.data == $past(((mem_wdata ^ dvalue_q) & dmask_q) == 32'h0))
    else $error("store data qualifier wrong");
  a_reset_clear: assert property ($rose(rst_n_q) |-> ibkpt_q[0] == 1'b0 && dctrl_q == 3'h0)
    else $error("enables not clear after reset");

  c_fetch_bkpt: cover property (fetch_bkpt_q);
  c_pabt_taken: cover property (abort_q.take && !abort_q.data);
  c_store_data_hit: cover property (abort_q.take && abort_q.data && dctrl_q[2]);
  c_refused: cover property (cp_rsp.refuse);

endmodule // core_breakpoint_unit
`default_nettype wire

// file: tb/core_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_pipe_model (
  // Clock
  input wire logic clk,
  // Fetch stage
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_pc,
  input wire logic fetch_bkpt_q,
  input wire logic flush_req,
  // Execute stage
  output logic exec_valid,
  output logic exec_bkpt_tag,
  output logic exec_flush,
  output logic [31:0] exec_pc
);
  logic [31:0] pc_q = 32'h0;
  initial begin
    exec_valid = 1'b0;
    exec_bkpt_tag = 1'b0;
    exec_flush = 1'b0;
    exec_pc = 32'h0;
  end
  always @(posedge clk) begin
    if (fetch_valid) pc_q <= fetch_pc;
  end
  // Marked fetch reaches execute next cycle; idle pc toggles so no stale value
  always @(negedge clk) begin
    exec_valid <= fetch_bkpt_q;
    exec_bkpt_tag <= fetch_bkpt_q;
    exec_flush <= fetch_bkpt_q & flush_req;
    exec_pc <= fetch_bkpt_q ? pc_q : ~exec_pc;
  end
endmodule // core_pipe_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  bkpt_pkg::cp_req_type cp_req = '0;
  bkpt_pkg::cp_rsp_type cp_rsp;
  bkpt_pkg::abort_type abort_q;
  logic fetch_valid = 1'b0, flush_req = 1'b0, mem_valid = 1'b0, mem_store = 1'b0;
  logic [31:0] fetch_addr = '0, fetch_pc = '0, mem_addr = '0, mem_wdata = '0;
  logic [31:0] mem_pc = '0, cur_status = '0, a, v, m;
  logic exec_valid, exec_bkpt_tag, exec_flush, fetch_bkpt_q;
  logic [31:0] exec_pc, fault_status_q;
  int mismatches = 0, compares = 0, seed = 70784;
  logic [33:0] rq[$];
  bkpt_pkg::abort_type aq[$];

  always #5 clk = ~clk;

  core_breakpoint_unit DUT (.clk(clk), .rstn(rstn), .cp_req(cp_req), .cp_rsp(cp_rsp),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_pc(fetch_pc),
    .fetch_bkpt_q(fetch_bkpt_q), .exec_valid(exec_valid), .exec_bkpt_tag(exec_bkpt_tag),
    .exec_flush(exec_flush), .exec_pc(exec_pc), .cur_status(cur_status),
    .mem_valid(mem_valid), .mem_store(mem_store), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_pc(mem_pc), .fault_status_q(fault_status_q),
    .abort_q(abort_q));
  core_pipe_model core_model (.clk(clk), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
    .fetch_bkpt_q(fetch_bkpt_q), .flush_req(flush_req), .exec_valid(exec_valid),
    .exec_bkpt_tag(exec_bkpt_tag), .exec_flush(exec_flush), .exec_pc(exec_pc));

  task automatic check(input logic [191:0] seen, input logic [191:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic bkpt_pkg::abort_type ab(input logic d, input logic [31:0] pc);
    ab = '0;
    ab.take = 1'b1;
    ab.data = d;
    ab.link = pc + (d ? 32'h8 : 32'h4);
    ab.saved_status = cur_status;
    ab.new_status = {cur_status[31:8], 1'b1, cur_status[6:5], 5'b10111};
    ab.vector = d ? 32'h10 : 32'hc;
  endfunction

  // Two cycles per access so valid never changes twice in one step
  task automatic cp(input logic w, input logic p, input logic [3:0] crn,
      input logic [2:0] s, input logic [31:0] d, input logic [33:0] e);
    if (crn == 4'he) rq.push_back(e);
    cp_req = '{valid: 1'b1, write: w, priv: p, crn: crn, sel: s, wdata: d};
    @(negedge clk);
    cp_req.valid = 1'b0;
    @(negedge clk);
    check(rq.size(), 0);
  endtask

  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    cp(1'b1, 1'b1, 4'he, s, d, {2'b10, 32'h0});
  endtask

  task automatic rd(input logic [2:0] s, input logic [31:0] e);
    cp(1'b0, 1'b1, 4'he, s, 32'h0, {2'b10, e});
  endtask

  task automatic fetch(input logic [31:0] ad, input logic [31:0] pc, input logic fl,
      input logic hit);
    if (hit) aq.push_back(ab(1'b0, pc));
    fetch_valid = 1'b1;
    fetch_addr = ad;
    fetch_pc = pc;
    flush_req = fl;
    @(negedge clk);
    fetch_valid = 1'b0;
    repeat (3) @(negedge clk);
    flush_req = 1'b0;
    check(aq.size(), 0);
  endtask

  task automatic mem(input logic st, input logic [31:0] ad, input logic [31:0] wd,
      input logic hit);
    mem_pc = $random(seed);
    if (hit) aq.push_back(ab(1'b1, mem_pc));
    mem_valid = 1'b1;
    mem_store = st;
    mem_addr = ad;
    mem_wdata = wd;
    @(negedge clk);
    mem_valid = 1'b0;
    repeat (2) @(negedge clk);
    check(aq.size(), 0);
  endtask

  always @(negedge clk) begin
    if (cp_rsp.ack === 1'b1 || cp_rsp.refuse === 1'b1) begin
      check({cp_rsp.ack, cp_rsp.refuse, cp_rsp.rdata}, rq.size() ? rq.pop_front() : '1);
    end
    if (abort_q.take === 1'b1) begin
      check(abort_q, aq.size() ? aq.pop_front() : '1);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    cur_status = $random(seed);
    for (int i = 0; i < 6; i++) rd(i[2:0], 32'h0);
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      wr(i[2:0], v);
      rd(i[2:0], i == 4 ? {29'h0, v[2:0]} : v);
    end
    $display("test regs done");
    a = $random(seed);
    wr(3'h1, a);
    cp(1'b1, 1'b0, 4'he, 3'h1, ~a, {2'b01, 32'h0});
    cp(1'b0, 1'b1, 4'he, 3'h6, 32'h0, {2'b01, 32'h0});
    cp(1'b1, 1'b1, 4'hd, 3'h1, ~a, '0);
    rd(3'h1, a);
    $display("test refuse done");
    wr(3'h0, {a[31:2], 2'b01});
    fetch({a[31:2], 2'b11}, {a[31:2], 2'b10}, 1'b0, 1'b1);
    fetch(a, a ^ 32'h4, 1'b0, 1'b0);
    fetch(a ^ 32'h4, a, 1'b0, 1'b0);
    fetch(a, a, 1'b1, 1'b0);
    wr(3'h0, {a[31:2], 2'b00});
    fetch(a, a, 1'b0, 1'b0);
    $display("test fetch done");
    v = $random(seed);
    m = $random(seed) | 1;
    wr(3'h2, v);
    wr(3'h3, m);
    wr(3'h5, 32'h0);
    wr(3'h4, 32'h1);
    mem(1'b0, a, ~a, 1'b1);
    check(fault_status_q, 32'h0000_0200);
    rd(3'h5, 32'h0000_0200);
    mem(1'b0, a ^ 32'h1, a, 1'b0);
    mem(1'b1, a, v, 1'b0);
    wr(3'h4, 32'h4);
    mem(1'b1, a, v, 1'b0);
    wr(3'h4, 32'h6);
    mem(1'b1, a, v ^ ~m, 1'b1);
    mem(1'b1, a, v ^ 32'h1, 1'b0);
    wr(3'h4, 32'h2);
    mem(1'b1, a, ~v, 1'b1);
    $display("test data done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
